//--- hw/osw_defs.svh
// Constants of the octal switch serial control block
`ifndef OSW_DEFS_SVH
`define OSW_DEFS_SVH
`define OSW_CHANNELS 8
`define OSW_CLK_MHZ 250
`define OSW_FILTER_US 300
`define OSW_FILTER_CYCLES (`OSW_FILTER_US * `OSW_CLK_MHZ)
`define OSW_CMD_RESET 8'h00
`define OSW_FAULT_RESET 8'h00
`endif

//--- hw/osw_pkg.sv
// Types of the octal switch serial control block
package osw_pkg;
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_FRAME,
		PH_FILTER
	} osw_phase_type;
	typedef logic [7:0] osw_word_type;
endpackage : osw_pkg

//--- hw/osw_xfer_if.sv
// Words passed between the link shifter and the core
`timescale 1ns/1ps
interface osw_xfer_if;
	osw_pkg::osw_word_type rx_word; // Last eight bits shifted in
	osw_pkg::osw_word_type tx_word; // Fault word frozen for the frame
	modport link (output rx_word, input tx_word);
	modport core (input rx_word, output tx_word);
endinterface : osw_xfer_if

//--- hw/osw_link.sv
// Serial shifter running on the link clock
`timescale 1ns/1ps
`include "osw_defs.svh"
module osw_link (
	input wire logic sclk, // Link clock from the host
	input wire logic rst_n, // Core reset, asynchronous
	input wire logic cs_n, // Frame select, low in frame
	input wire logic di, // Serial data from the host
	output logic do_bit, // Serial data to the host
	osw_xfer_if.link xfer // Words to and from the core
);
	localparam int MSB = `OSW_CHANNELS - 1;
	logic started;
	logic frame_rst_n;
	osw_pkg::osw_word_type shreg;

	// Link clock stops between frames, so the select ends the frame
	assign frame_rst_n = rst_n & ~cs_n;

	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	// Received bits follow the fault bits out, so devices can chain
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			shreg <= `OSW_CMD_RESET;
		end else if (!started) begin
			shreg <= {xfer.tx_word[MSB-1:0], di};
		end else begin
			shreg <= {shreg[MSB-1:0], di};
		end
	end

	assign do_bit = started ? shreg[MSB] : xfer.tx_word[MSB];
	assign xfer.rx_word = shreg;

	chk_shift_msb_first: assert property (
		@(posedge sclk) disable iff (!frame_rst_n)
		started |=> shreg[0] == $past(di) && shreg[MSB] == $past(shreg[MSB-1])
	) else $error("serial shift order broken");
endmodule : osw_link

//--- hw/osw_chan.sv
// Per-output switch control and fault latch
`timescale 1ns/1ps
module osw_chan (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic cmd_on, // Commanded state of this output
	input wire logic hot, // Thermal limit reached
	input wire logic over_current, // Current limit or short to supply
	input wire logic open_off, // Open load comparator
	input wire logic open_enable, // Open load sensing allowed
	input wire logic global_off, // Supply shutdown of all outputs
	input wire logic wipe, // Logic supply low
	input wire logic clear, // Fault word taken by a frame
	output logic drive, // Output switch on
	output logic fault // Latched fault bit
);
	logic next_drive;
	logic fault_set;

	// No retry timer: cooling below hysteresis drops hot by itself
	assign next_drive = cmd_on & ~hot & ~global_off;
	// Open load while on is never sensed
	assign fault_set = hot | (cmd_on & over_current)
		| (~cmd_on & open_off & open_enable);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive <= 1'b0;
		end else begin
			drive <= next_drive;
		end
	end

	// Set wins over the read clear so no event is lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault <= 1'b0;
		end else if (wipe) begin
			fault <= 1'b0;
		end else if (fault_set) begin
			fault <= 1'b1;
		end else if (clear) begin
			fault <= 1'b0;
		end
	end

	chk_hot_isolates: assert property (
		@(posedge clk) disable iff (!rst_n)
		hot |=> !drive
	) else $error("hot output not switched off");

	chk_auto_retry: assert property (
		@(posedge clk) disable iff (!rst_n)
		$fell(hot) && cmd_on && !global_off |=> drive
	) else $error("cooled output not reasserted");

	chk_on_open_quiet: assert property (
		@(posedge clk) disable iff (!rst_n)
		!fault && cmd_on && !hot && !over_current |=> !fault
	) else $error("fault flagged without cause");
endmodule : osw_chan

//--- hw/osw_top.sv
// Top of the octal switch serial control and fault reporting block
// What this block does
// - Hot shorted output cycles off, then retries
// - Logic undervoltage: all off, fault word cleared
// - Low load supply never shuts outputs down
// - Each frame: command in, fault out
// - Both words travel most significant bit first
// - Top bit is channel eight, bottom one
// - Command one is on; fault one flags
// - Flag overtemperature, overcurrent, off-state open load
// - Open load while on is not flagged
// - Load overvoltage: all off, then resume command
// - Overtemperature switches off only that output
// - Command applies at the select rising edge
// - Fault word reports the previous command period
// - Select rise starts filter; open load latched
`timescale 1ns/1ps
`include "osw_defs.svh"
module osw_top #(
	parameter int CHANNELS = `OSW_CHANNELS, // Output channels
	parameter int FILTER_CYCLES = `OSW_FILTER_CYCLES // Open load filter
) (
	input wire logic REF_CLK, // Core clock, 250 MHz
	input wire logic RST_N, // Asynchronous reset, active low
	input wire logic SCLK, // Serial link clock from the host
	input wire logic CS_N, // Frame select, active low
	input wire logic DI, // Serial command data in
	output logic DO, // Serial fault data out
	output logic DO_EN_N, // Data out enable, low while driving
	output logic [CHANNELS-1:0] OUT_ON, // Output switch drives
	input wire logic [CHANNELS-1:0] HOT, // Per-output thermal limit
	input wire logic [CHANNELS-1:0] OVER_CURRENT, // Per-output short
	input wire logic [CHANNELS-1:0] OPEN_OFF, // Off-state open load
	input wire logic VDD_LOW, // Logic supply undervoltage
	input wire logic LOAD_OVER, // Load supply overvoltage
	input wire logic LOAD_LOW, // Load supply below 9 V
	output logic STATUS_SUSPECT // Fault word may be unreliable
);
	localparam int SYNC_W = 3 * CHANNELS + 4;
	localparam int TW = $clog2(FILTER_CYCLES + 1);
	localparam logic [SYNC_W-1:0] SYNC_RESET = SYNC_W'(1);

	if (CHANNELS != `OSW_CHANNELS || FILTER_CYCLES < 16) begin : g_bad
		$error("osw_top: unsupported parameter values");
	end

	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	osw_xfer_if xfer ();

	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic [CHANNELS-1:0] hot_s;
	logic [CHANNELS-1:0] oc_s;
	logic [CHANNELS-1:0] open_s;
	logic vdd_low_s;
	logic over_s;
	logic low_s;
	logic cs_s;

	osw_pkg::osw_phase_type phase;
	osw_pkg::osw_phase_type next_phase;
	logic [TW-1:0] timer;
	logic timer_done;
	logic frame_end;
	logic frame_start;
	logic open_enable;
	logic global_off;

	osw_pkg::osw_word_type cmd_word;
	osw_pkg::osw_word_type fault_snap;
	logic [CHANNELS-1:0] fault_vec;
	logic [CHANNELS-1:0] drive_vec;

	// Pin inputs cross in with two flops; select idles high
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_a <= SYNC_RESET;
		end else begin
			sync_a <= {HOT, OVER_CURRENT, OPEN_OFF,
				VDD_LOW, LOAD_OVER, LOAD_LOW, CS_N};
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_b <= SYNC_RESET;
		end else begin
			sync_b <= sync_a;
		end
	end

	assign {hot_s, oc_s, open_s, vdd_low_s, over_s, low_s, cs_s} = sync_b;

	// Link logic runs on the host clock
	osw_link u_link (
		.sclk(SCLK),
		.rst_n(RST_N),
		.cs_n(CS_N),
		.di(DI),
		.do_bit(DO),
		.xfer(xfer.link)
	);

	assign DO_EN_N = CS_N;

	assign timer_done = timer == TW'(FILTER_CYCLES - 1);
	assign frame_end = phase == osw_pkg::PH_FRAME && cs_s;
	assign frame_start = phase != osw_pkg::PH_FRAME && !cs_s;

	always_comb begin
		next_phase = phase;
		case (phase)
			osw_pkg::PH_IDLE: begin
				if (!cs_s) begin
					next_phase = osw_pkg::PH_FRAME;
				end
			end
			osw_pkg::PH_FRAME: begin
				if (cs_s) begin
					next_phase = osw_pkg::PH_FILTER;
				end
			end
			osw_pkg::PH_FILTER: begin
				if (!cs_s) begin
					next_phase = osw_pkg::PH_FRAME;
				end else if (timer_done) begin
					next_phase = osw_pkg::PH_IDLE;
				end
			end
			default: begin
				next_phase = osw_pkg::PH_IDLE;
			end
		endcase
	end

	// Power-up also waits out the filter before open load sensing
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			phase <= osw_pkg::PH_FILTER;
		end else begin
			phase <= next_phase;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			timer <= '0;
		end else if (phase != osw_pkg::PH_FILTER) begin
			timer <= '0;
		end else if (!timer_done) begin
			timer <= timer + TW'(1);
		end
	end

	// Switching transients would look like open loads
	assign open_enable = phase == osw_pkg::PH_IDLE;

	// Load supply low is deliberately absent here
	assign global_off = vdd_low_s | over_s;

	// Undervoltage drops the command so outputs stay off afterwards
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_word <= `OSW_CMD_RESET;
		end else if (vdd_low_s) begin
			cmd_word <= `OSW_CMD_RESET;
		end else if (frame_end) begin
			cmd_word <= xfer.rx_word;
		end
	end

	// Frozen while the select is low; the link reads it unsynchronised
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fault_snap <= `OSW_FAULT_RESET;
		end else if (vdd_low_s) begin
			fault_snap <= `OSW_FAULT_RESET;
		end else if (cs_s && phase != osw_pkg::PH_FRAME) begin
			fault_snap <= fault_vec;
		end
	end

	assign xfer.tx_word = fault_snap;

	// Bit i is channel i+1: channel eight sits at the top
	for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
		osw_chan u_chan (
			.clk(REF_CLK),
			.rst_n(RST_N),
			.cmd_on(cmd_word[i]),
			.hot(hot_s[i]),
			.over_current(oc_s[i]),
			.open_off(open_s[i]),
			.open_enable(open_enable),
			.global_off(global_off),
			.wipe(vdd_low_s),
			.clear(frame_start),
			.drive(drive_vec[i]),
			.fault(fault_vec[i])
		);
	end

	assign OUT_ON = drive_vec;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			STATUS_SUSPECT <= 1'b0;
		end else begin
			STATUS_SUSPECT <= low_s;
		end
	end

	// Checker-only helpers; the counter runs apart from the filter timer
	logic [CHANNELS-1:0] open_seen;
	logic [CHANNELS-1:0] oc_seen;
	logic [CHANNELS-1:0] on_quiet;
	logic [TW-1:0] quiet_count;

	assign open_seen = open_s & ~cmd_word & {CHANNELS{open_enable}};
	assign oc_seen = oc_s & cmd_word;
	assign on_quiet = cmd_word & ~hot_s & ~oc_s;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			quiet_count <= '0;
		end else if (!cs_s || frame_end) begin
			quiet_count <= '0;
		end else if (quiet_count != TW'(FILTER_CYCLES)) begin
			quiet_count <= quiet_count + TW'(1);
		end
	end

	sequence s_frame_end;
		phase == osw_pkg::PH_FRAME && cs_s;
	endsequence

	sequence s_quiet_filter;
		cs_s && !open_enable;
	endsequence

	sequence s_healthy;
		!vdd_low_s && !over_s && hot_s == '0;
	endsequence

	sequence s_filter_running;
		cs_s && quiet_count != TW'(FILTER_CYCLES);
	endsequence

	sequence s_filter_done;
		cs_s && quiet_count == TW'(FILTER_CYCLES);
	endsequence

	chk_cmd_commit: assert property (
		s_frame_end and !vdd_low_s |=> cmd_word == $past(xfer.rx_word)
	) else $error("command not applied at select rise");

	chk_cmd_held: assert property (
		!cs_s && !vdd_low_s |=> $stable(cmd_word)
	) else $error("command changed inside a frame");

	chk_uv_clear: assert property (
		vdd_low_s |=> fault_snap == '0 && cmd_word == '0 ##1 OUT_ON == '0
	) else $error("undervoltage did not clear and shut down");

	chk_ov_all_off: assert property (
		over_s |=> OUT_ON == '0
	) else $error("overvoltage left an output on");

	chk_ov_resume: assert property (
		$fell(over_s) ##0 s_healthy |=> OUT_ON == $past(cmd_word)
	) else $error("outputs did not resume after overvoltage");

	chk_low_supply_runs: assert property (
		low_s ##0 s_healthy |=> OUT_ON == $past(cmd_word)
	) else $error("low load supply disturbed the outputs");

	chk_filter_hold: assert property (
		s_frame_end |=> s_quiet_filter [*8]
	) else $error("open load sensing enabled inside the filter");

	chk_filter_expire: assert property (
		cs_s && phase == osw_pkg::PH_FILTER && timer_done
		|=> open_enable
	) else $error("filter did not expire on time");

	chk_snapshot: assert property (
		cs_s && !vdd_low_s && phase != osw_pkg::PH_FRAME
		|=> fault_snap == $past(fault_vec)
	) else $error("fault word not tracking the latches");

	chk_snapshot_frozen: assert property (
		!cs_s && !vdd_low_s ##1 !cs_s && !vdd_low_s |-> $stable(fault_snap)
	) else $error("fault word moved inside a frame");

	chk_fault_visible: assert property (
		(hot_s != '0) && !vdd_low_s
		|=> (fault_vec & $past(hot_s)) == $past(hot_s)
	) else $error("overtemperature not latched as a fault");

	chk_filter_length: assert property (
		s_filter_running |-> !open_enable
	) else $error("open load sensing enabled before the filter ran out");

	chk_filter_ends: assert property (
		s_filter_done |-> open_enable
	) else $error("open load sensing not enabled after the filter");

	chk_cmd_idle: assert property (
		cs_s && phase != osw_pkg::PH_FRAME && !vdd_low_s
		|=> $stable(cmd_word)
	) else $error("command changed outside a frame end");

	chk_cmd_gates_out: assert property (
		1'b1 |=> (OUT_ON & ~$past(cmd_word)) == '0
	) else $error("output on without a command");

	chk_hot_only: assert property (
		!vdd_low_s && !over_s
		|=> OUT_ON == ($past(cmd_word) & ~$past(hot_s))
	) else $error("thermal shutdown touched another output");

	chk_uv_all_off: assert property (
		vdd_low_s |=> OUT_ON == '0
	) else $error("undervoltage left an output on");

	chk_uv_latches: assert property (
		vdd_low_s |=> fault_vec == '0
	) else $error("undervoltage left a fault latched");

	chk_suspect_flag: assert property (
		low_s |=> STATUS_SUSPECT
	) else $error("low load supply not flagged");

	chk_open_latched: assert property (
		open_seen != '0 && !vdd_low_s
		|=> (fault_vec & $past(open_seen)) == $past(open_seen)
	) else $error("off-state open load not latched");

	chk_short_latched: assert property (
		oc_seen != '0 && !vdd_low_s
		|=> (fault_vec & $past(oc_seen)) == $past(oc_seen)
	) else $error("overcurrent not latched as a fault");

	chk_on_open_silent: assert property (
		!vdd_low_s
		|=> (fault_vec & ~$past(fault_vec) & $past(on_quiet)) == '0
	) else $error("healthy on output flagged a fault");
endmodule : osw_top

//--- tb/osw_host.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module osw_host (
	output logic sclk, // Link clock, still outside frames
	output logic cs_n, // Frame select
	output logic di, // Command data to the device
	input wire logic do_bit, // Fault data from the device
	input wire logic do_en_n // Low while the device drives data
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		di = 1'b0;
	end
	task automatic frame(input osw_pkg::osw_word_type cmd,
		output osw_pkg::osw_word_type flt);
		cs_n = 1'b0;
		#16;  // Fault word freezes first; link edges miss core edges
		for (int i = 7; i >= 0; i--) begin
			di = cmd[i];
			#2;
			flt[i] = do_en_n ? 1'bx : do_bit;
			#1 sclk = 1'b1;
			#3 sclk = 1'b0;
		end
		#3 cs_n = 1'b1;
		di = ~di; // Released line must not pass for data
	endtask : frame
endmodule : osw_host

//--- tb/osw_top_tb_top.sv
// Self-checking bench of the octal switch serial control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module osw_top_tb_top;
	logic ref_clk = 1'b0;
	logic rst_n, vdd_low, load_over, load_low, suspect;
	logic [7:0] hot, oc, open_off, out_on;
	wire sclk, cs_n, di, do_bit, do_en_n;
	int err_count = 0;
	int checked = 0;
	osw_pkg::osw_word_type corner [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};
	always #2 ref_clk = ~ref_clk;
	osw_top #(.FILTER_CYCLES(20)) osw_top_inst (.REF_CLK(ref_clk),
		.RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .DI(di), .DO(do_bit),
		.DO_EN_N(do_en_n), .OUT_ON(out_on), .HOT(hot), .OVER_CURRENT(oc),
		.OPEN_OFF(open_off), .VDD_LOW(vdd_low), .LOAD_OVER(load_over),
		.LOAD_LOW(load_low), .STATUS_SUSPECT(suspect));
	osw_host osw_host_inst (.sclk(sclk), .cs_n(cs_n), .di(di),
		.do_bit(do_bit), .do_en_n(do_en_n));
	function automatic osw_pkg::osw_word_type exp_fault(
		input osw_pkg::osw_word_type cmd, h, c, o);
		return h | (c & cmd) | (o & ~cmd);
	endfunction : exp_fault
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic finish_test;
		$display("Counts: %0d checks, %0d mismatches", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	initial begin
		#200000;
		err_count++;
		finish_test;
	end
	initial begin
		osw_pkg::osw_word_type cmd, last, prev, flt, h, c, o;
		void'($urandom(80));
		{rst_n, vdd_low, load_over, load_low} = 4'h0;
		{hot, oc, open_off} = 24'h00_0000;
		cyc(20);
		rst_n = 1'b1;
		cyc(4);
		prev = 8'h00;
		last = 8'h00;
		for (int i = 0; i < 10; i++) begin
			cmd = (i < 4) ? corner[i] : 8'($urandom);
			h = 8'($urandom & $urandom & $urandom);
			c = 8'($urandom & $urandom) & ~h;
			o = 8'($urandom & $urandom);
			osw_host_inst.frame(cmd, flt);
			`CHK("fault word", prev, flt)
			cyc(1);
			`CHK("output held", last, out_on)
			cyc(6);
			`CHK("output", cmd, out_on)
			cyc(30);
			hot = h;
			oc = c;
			open_off = o;
			cyc(6);
			`CHK("thermal off", cmd & ~h, out_on)
			osw_host_inst.frame(cmd, flt);
			`CHK("fault kinds", exp_fault(cmd, h, c, o), flt)
			cyc(40);  // Spacing scaled with the short filter
			{hot, oc, open_off} = 24'h00_0000;
			cyc(6);
			`CHK("retry", cmd, out_on)
			prev = exp_fault(cmd, h, c, o); // Latched until read
			last = cmd;
			$display("Test %0d done", i);
		end
		load_low = 1'b1;
		osw_host_inst.frame(8'hA5, flt);
		cyc(7);
		`CHK("low load output", 8'hA5, out_on)
		`CHK("status suspect", 1'b1, suspect)
		load_low = 1'b0;
		load_over = 1'b1;
		cyc(6);
		`CHK("overvoltage off", 8'h00, out_on)
		load_over = 1'b0;
		cyc(6);
		`CHK("overvoltage resume", 8'hA5, out_on)
		$display("Test load supply done");
		hot = 8'h3C;
		cyc(6);
		vdd_low = 1'b1;
		cyc(6);
		`CHK("undervoltage off", 8'h00, out_on)
		hot = 8'h00;
		cyc(1);
		vdd_low = 1'b0;
		cyc(6);
		`CHK("after recovery", 8'h00, out_on)
		osw_host_inst.frame(8'h0F, flt);
		`CHK("cleared fault", 8'h00, flt)
		cyc(7);
		`CHK("new command", 8'h0F, out_on)
		$display("Test logic supply done");
		finish_test;
	end
endmodule : osw_top_tb_top
